// >>> branch_trap_exec.sv
`timescale 1ns/1ns
`include "branch_trap_consts.svh"
// Overview of operation
// - Branch-not-equal takes the short branch only when the zero flag is clear.
// - Branch-no-overflow (opcode 71h) branches only when overflow is zero.
// - Branch-positive (opcode 79h) branches only when sign is zero.
// - Branch-parity-even (opcode 7ah) branches only when parity is one.
// - Branch-parity-odd (opcode 7bh) branches only when parity is zero.
// - A taken conditional branch adds the sign-extended 8-bit displacement to the counter.
// - Near jump adds a 16-bit displacement; the instruction is three bytes.
// - Short jump adds the sign-extended displacement without a flag test.
// - Register or memory word jump loads the counter and keeps the segment.
// - Far jump loads the counter from bytes two-three and segment from four-five.
// - Indirect far jump loads segment from the high and counter from the low word.
// - A trap pushes status, segment, counter, each after stack-2, clears int-enable and step.
// - The one-byte trap reads the counter at 00ch and segment at 00eh.
// - The two-byte trap reads the counter at operand*4 and segment at operand*4+2.
// - The emulation trap pushes like a trap, clears the mode flag, and vectors.
module branch_trap_exec
  import branch_trap_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  byte0_i,
  input  wire logic [7:0]  byte1_i,
  input  wire logic [7:0]  byte2_i,
  input  wire logic [7:0]  byte3_i,
  input  wire logic [7:0]  byte4_i,
  input  wire logic [15:0] reg_operand_i,
  input  wire logic [31:0] mem_operand_i,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             illegal_o,
  output logic [15:0]      pc_o,
  output logic [15:0]      ps_o,
  output logic [15:0]      sp_o,
  output logic [15:0]      psw_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic [15:0]      mem_addr_o,
  output logic [15:0]      mem_wdata_o
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  trap_state_type state_q;
  logic [15:0]    pc_q;
  logic [15:0]    ps_q;
  logic [15:0]    sp_q;
  logic [15:0]    psw_q;
  logic [15:0]    vec_q;
  logic [15:0]    new_pc_q;
  logic [15:0]    new_ps_q;
  logic           emu_q;
  logic           done_q;
  logic           illegal_q;
  logic           busy_q;
  logic           is_cond;
  logic           cond_taken;
  logic [15:0]    ext_disp8;
  logic [15:0]    disp16;
  logic [15:0]    imm_vec;
  logic           is_grp;
  logic [2:0]     grp_sel;
  logic           grp_reg;
  logic           is_emu;
  logic           is_trap;
  trap_mem_if     mif ();

  ////////////////////////////////////////////////////////////////////////
  // Flag test
  cond_eval u_cond (
    .opcode_i  (byte0_i),
    .psw_i     (psw_q),
    .is_cond_o (is_cond),
    .taken_o   (cond_taken)
  );

  ////////////////////////////////////////////////////////////////////////
  // Trap memory sequencer
  trap_seq u_seq (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .state_i (state_q),
    .sp_i    (sp_q),
    .vec_i   (vec_q),
    .psw_i   (psw_q),
    .ps_i    (ps_q),
    .pc_i    (pc_q),
    .m       (mif.seq)
  );

  // Memory port hookup
  assign mif.rdata = mem_rdata_i;
  assign mif.ack   = mem_ack_i;

  ////////////////////////////////////////////////////////////////////////
  // Operand decode
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

  assign ext_disp8 = sext8(byte1_i);
  assign disp16    = {byte2_i, byte1_i};
  assign imm_vec   = {6'h00, byte1_i, 2'b00};
  assign is_grp    = (byte0_i == `OP_GRP_FF);
  assign grp_sel   = byte1_i[5:3];
  assign grp_reg   = (byte1_i[7:6] == 2'b11);
  assign is_emu    = (byte0_i == `OP_ESC0F) && (byte1_i == `OP_EMU2);
  assign is_trap   = (byte0_i == `OP_TRAP3) || (byte0_i == `OP_TRAPN) || is_emu;

  ////////////////////////////////////////////////////////////////////////
  // Trap state machine
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start_i && is_trap) state_q <= ST_VLO;
        ST_VLO:  if (mem_ack_i) state_q <= ST_VHI;
        ST_VHI:  if (mem_ack_i) state_q <= ST_PSW;
        ST_PSW:  if (mem_ack_i) state_q <= ST_SEG;
        ST_SEG:  if (mem_ack_i) state_q <= ST_PC;
        ST_PC:   if (mem_ack_i) state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vector address and mode latch
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vec_q <= 16'h0000;
      emu_q <= 1'b0;
    end else if (state_q == ST_IDLE && start_i && is_trap) begin
      emu_q <= is_emu;
      if (byte0_i == `OP_TRAP3) begin
        vec_q <= `VEC3_ADDR;
      end else if (is_emu) begin
        vec_q <= {6'h00, byte2_i, 2'b00};
      end else begin
        vec_q <= imm_vec;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetched vector words
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      new_pc_q <= 16'h0000;
      new_ps_q <= 16'h0000;
    end else begin
      if (state_q == ST_VLO && mem_ack_i) new_pc_q <= mem_rdata_i;
      if (state_q == ST_VHI && mem_ack_i) new_ps_q <= mem_rdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sp_q <= `RST_STACK;
    end else if ((state_q == ST_PSW || state_q == ST_SEG || state_q == ST_PC)
                 && mem_ack_i) begin
      sp_q <= sp_q - `PUSH_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      psw_q <= `RST_STATUS;
    end else if (state_q == ST_PSW && mem_ack_i) begin
      psw_q[`FLG_INT_EN] <= 1'b0;
      psw_q[`FLG_STEP]   <= 1'b0;
      if (emu_q) psw_q[`FLG_MODE] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program segment
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ps_q <= `RST_SEGMENT;
    end else if (state_q == ST_SEG && mem_ack_i) begin
      ps_q <= new_ps_q;
    end else if (state_q == ST_IDLE && start_i) begin
      if (byte0_i == `OP_JMP_FAR) begin
        ps_q <= {byte4_i, byte3_i};
      end else if (is_grp && grp_sel == `GRP_JMP_FAR && !grp_reg) begin
        ps_q <= mem_operand_i[31:16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pc_q <= `RST_COUNTER;
    end else if (state_q == ST_PC && mem_ack_i) begin
      pc_q <= new_pc_q;
    end else if (state_q == ST_IDLE && start_i) begin
      if (is_cond) begin
        if (cond_taken) begin
          pc_q <= pc_q + `LEN_SHORT + ext_disp8;
        end else begin
          pc_q <= pc_q + `LEN_SHORT;
        end
      end else if (byte0_i == `OP_JMP_SHORT) begin
        pc_q <= pc_q + `LEN_SHORT + ext_disp8;
      end else if (byte0_i == `OP_JMP_NEAR) begin
        pc_q <= pc_q + `LEN_NEAR + disp16;
      end else if (byte0_i == `OP_JMP_FAR) begin
        pc_q <= {byte2_i, byte1_i};
      end else if (is_grp && grp_sel == `GRP_JMP_NEAR) begin
        pc_q <= grp_reg ? reg_operand_i : mem_operand_i[15:0];
      end else if (is_grp && grp_sel == `GRP_JMP_FAR && !grp_reg) begin
        pc_q <= mem_operand_i[15:0];
      end else if (byte0_i == `OP_TRAP3) begin
        pc_q <= pc_q + `LEN_TRAP3;
      end else if (byte0_i == `OP_TRAPN) begin
        pc_q <= pc_q + `LEN_TRAPN;
      end else if (is_emu) begin
        pc_q <= pc_q + `LEN_EMU;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion and illegal-code flags
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
      if (state_q == ST_PC && mem_ack_i) begin
        done_q <= 1'b1;
      end else if (state_q == ST_IDLE && start_i && !is_trap) begin
        if (is_cond || byte0_i == `OP_JMP_SHORT || byte0_i == `OP_JMP_NEAR
            || byte0_i == `OP_JMP_FAR
            || (is_grp && grp_sel == `GRP_JMP_NEAR)
            || (is_grp && grp_sel == `GRP_JMP_FAR && !grp_reg)) begin
          done_q <= 1'b1;
        end else begin
          illegal_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered memory port
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 16'h0000;
    end else begin
      mem_rd_o    <= (mif.op == MEM_RD) && !mem_ack_i;
      mem_wr_o    <= (mif.op == MEM_WR) && !mem_ack_i;
      mem_addr_o  <= mif.addr;
      mem_wdata_o <= mif.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy flag, held in its own flop so the port is registered
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
    end else if (state_q == ST_IDLE && start_i && is_trap) begin
      busy_q <= 1'b1;
    end else if (state_q == ST_DONE) begin
      busy_q <= 1'b0;
    end
  end

  // Architectural outputs
  assign busy_o    = busy_q;
  assign done_o    = done_q;
  assign illegal_o = illegal_q;
  assign pc_o      = pc_q;
  assign ps_o      = ps_q;
  assign sp_o      = sp_q;
  assign psw_o     = psw_q;
endmodule

// >>> branch_trap_consts.svh
`ifndef BRANCH_TRAP_CONSTS_SVH
`define BRANCH_TRAP_CONSTS_SVH
// Opcodes, first byte; OP_EMU2 is the second byte
`define OP_NO_OVF     8'h71
`define OP_NOT_EQUAL  8'h75
`define OP_NOT_HIGHER 8'h76
`define OP_POSITIVE   8'h79
`define OP_PAR_EVEN   8'h7a
`define OP_PAR_ODD    8'h7b
`define OP_JMP_NEAR   8'he9
`define OP_JMP_FAR    8'hea
`define OP_JMP_SHORT  8'heb
`define OP_GRP_FF     8'hff
`define OP_TRAP3      8'hcc
`define OP_TRAPN      8'hcd
`define OP_ESC0F      8'h0f
`define OP_EMU2       8'hff
// Group ff reg field codes
`define GRP_JMP_NEAR  3'h4
`define GRP_JMP_FAR   3'h5
// Vector 3 address and step sizes
`define VEC3_ADDR     16'h000c
`define VEC_HI_OFS    16'h0002
`define PUSH_STEP     16'h0002
// Instruction lengths
`define LEN_SHORT     16'h0002
`define LEN_NEAR      16'h0003
`define LEN_FAR       16'h0005
`define LEN_TRAP3     16'h0001
`define LEN_TRAPN     16'h0002
`define LEN_EMU       16'h0003
// Status word flag positions
`define FLG_CARRY     0
`define FLG_PARITY    2
`define FLG_ZERO      6
`define FLG_SIGN      7
`define FLG_STEP      8
`define FLG_INT_EN    9
`define FLG_OVF       11
`define FLG_MODE      15
// Reset values
`define RST_COUNTER   16'h0000
`define RST_SEGMENT   16'hffff
`define RST_STACK     16'h0000
`define RST_STATUS    16'h8000
`endif

// >>> branch_trap_pkg.sv
package branch_trap_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_VLO   = 7'b0000010,
    ST_VHI   = 7'b0000100,
    ST_PSW   = 7'b0001000,
    ST_SEG   = 7'b0010000,
    ST_PC    = 7'b0100000,
    ST_DONE  = 7'b1000000
  } trap_state_type;
  typedef enum logic [1:0] {
    MEM_NONE = 2'h0,
    MEM_RD   = 2'h1,
    MEM_WR   = 2'h2
  } mem_op_type;
endpackage

// >>> trap_mem_if.sv
`timescale 1ns/1ns
// Memory request carrier between sequencer and top
interface trap_mem_if;
  import branch_trap_pkg::*;
  mem_op_type  op;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  modport seq (output op, output addr, output wdata, input rdata, input ack);
  modport mem (input op, input addr, input wdata, output rdata, output ack);
endinterface

// >>> cond_eval.sv
`timescale 1ns/1ns
`include "branch_trap_consts.svh"
// Flag test for the short conditional branches
module cond_eval
  import branch_trap_pkg::*;
(
  input  wire logic [7:0]  opcode_i,
  input  wire logic [15:0] psw_i,
  output logic             is_cond_o,
  output logic             taken_o
);
  ////////////////////////////////////////////////////////////////////////
  // Condition select
  always_comb begin
    is_cond_o = 1'b1;
    taken_o   = 1'b0;
    unique case (opcode_i)
      `OP_NOT_EQUAL:  taken_o = ~psw_i[`FLG_ZERO];
      `OP_NOT_HIGHER: taken_o = psw_i[`FLG_CARRY] | psw_i[`FLG_ZERO];
      `OP_NO_OVF:     taken_o = ~psw_i[`FLG_OVF];
      `OP_POSITIVE:   taken_o = ~psw_i[`FLG_SIGN];
      `OP_PAR_EVEN:   taken_o = psw_i[`FLG_PARITY];
      `OP_PAR_ODD:    taken_o = ~psw_i[`FLG_PARITY];
      default: is_cond_o = 1'b0;
    endcase
  end
endmodule

// >>> trap_seq.sv
`timescale 1ns/1ns
`include "branch_trap_consts.svh"
// Address and data of each trap memory step
module trap_seq
  import branch_trap_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           rst_n_i,
  input  trap_state_type      state_i,
  input  wire logic [15:0]    sp_i,
  input  wire logic [15:0]    vec_i,
  input  wire logic [15:0]    psw_i,
  input  wire logic [15:0]    ps_i,
  input  wire logic [15:0]    pc_i,
  trap_mem_if.seq             m
);
  ////////////////////////////////////////////////////////////////////////
  // Step decode: vector reads, then pushes below the stack pointer
  always_comb begin
    m.op    = MEM_NONE;
    m.addr  = 16'h0000;
    m.wdata = 16'h0000;
    unique case (state_i)
      ST_VLO: begin
        m.op   = MEM_RD;
        m.addr = vec_i;
      end
      ST_VHI: begin
        m.op   = MEM_RD;
        m.addr = vec_i + `VEC_HI_OFS;
      end
      ST_PSW: begin
        m.op    = MEM_WR;
        m.addr  = sp_i - `PUSH_STEP;
        m.wdata = psw_i;
      end
      ST_SEG: begin
        m.op    = MEM_WR;
        m.addr  = sp_i - `PUSH_STEP;
        m.wdata = ps_i;
      end
      ST_PC: begin
        m.op    = MEM_WR;
        m.addr  = sp_i - `PUSH_STEP;
        m.wdata = pc_i;
      end
      default: m.op = MEM_NONE;
    endcase
  end
endmodule

// >>> branch_trap_exec_props.sv
`timescale 1ns/1ns
// Concurrent checks on the execution unit ports
module branch_trap_exec_props
  import branch_trap_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        start_i,
  input wire logic [7:0]  byte0_i,
  input wire logic [7:0]  byte1_i,
  input wire logic [7:0]  byte2_i,
  input wire logic [7:0]  byte3_i,
  input wire logic [7:0]  byte4_i,
  input wire logic [15:0] reg_operand_i,
  input wire logic [31:0] mem_operand_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        illegal_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] ps_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] psw_o,
  input wire logic        mem_rd_o,
  input wire logic [15:0] mem_addr_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Accepted start of a given opcode
  sequence s_go(logic [7:0] op);
    start_i && !busy_o && byte0_i == op;
  endsequence
  // Taken short branch lands on next address plus sign-extended offset
  property p_short(logic [7:0] op, logic take);
    s_go(op) ##0 take |=> pc_o == $past(pc_o) + 16'h0002
      + {{8{$past(byte1_i[7])}}, $past(byte1_i)};
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  chk_nonequal_taken: assert property (p_short(8'h75, !psw_o[6]))
    else $error("not-equal branch target wrong");
  chk_noovf_taken: assert property (p_short(8'h71, !psw_o[11]))
    else $error("no-overflow branch target wrong");
  chk_positive_taken: assert property (p_short(8'h79, !psw_o[7]))
    else $error("positive branch target wrong");
  chk_pareven_taken: assert property (p_short(8'h7a, psw_o[2]))
    else $error("parity-even branch target wrong");
  chk_parodd_taken: assert property (p_short(8'h7b, !psw_o[2]))
    else $error("parity-odd branch target wrong");
  chk_nothigher_fall: assert property (s_go(8'h76) ##0 !(psw_o[0] || psw_o[6])
    |=> done_o && pc_o == $past(pc_o) + 16'h0002 && $stable(psw_o))
    else $error("not-higher fall-through wrong");
  chk_near_jump: assert property (s_go(8'he9)
    |=> pc_o == $past(pc_o) + 16'h0003 + {$past(byte2_i), $past(byte1_i)})
    else $error("near jump target wrong");
  chk_far_jump: assert property (s_go(8'hea)
    |=> pc_o == $past({byte2_i, byte1_i}) && ps_o == $past({byte4_i, byte3_i}))
    else $error("far jump target wrong");
  chk_reg_jump: assert property (s_go(8'hff) ##0 byte1_i == 8'he0
    |=> pc_o == $past(reg_operand_i) && $stable(ps_o))
    else $error("register jump wrong");
  chk_far_indirect: assert property (s_go(8'hff) ##0 byte1_i == 8'h2f
    |=> {ps_o, pc_o} == $past(mem_operand_i))
    else $error("indirect far jump wrong");
  chk_trap_vector: assert property (s_go(8'hcc)
    |-> ##[1:4] mem_rd_o && mem_addr_o == 16'h000c)
    else $error("trap vector read missing");
  chk_illegal_quiet: assert property (illegal_o
    |-> $stable(pc_o) && $stable(ps_o) && $stable(sp_o))
    else $error("illegal opcode changed state");
endmodule

bind branch_trap_exec branch_trap_exec_props u_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start_i), .byte0_i(byte0_i),
  .byte1_i(byte1_i), .byte2_i(byte2_i), .byte3_i(byte3_i), .byte4_i(byte4_i),
  .reg_operand_i(reg_operand_i), .mem_operand_i(mem_operand_i), .busy_o(busy_o),
  .done_o(done_o), .illegal_o(illegal_o), .pc_o(pc_o), .ps_o(ps_o), .sp_o(sp_o),
  .psw_o(psw_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o)
);

// >>> branch_and_trap_execution_tb_top.sv
`timescale 1ns/1ns
// Directed bench for the branch and trap unit
module branch_and_trap_execution_tb_top;
  import branch_trap_pkg::*;
  logic        mclk_i        = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic        start_i       = 1'b0;
  logic [39:0] ins           = 40'h0;
  logic [15:0] reg_operand_i = 16'h1234;
  logic [31:0] mem_operand_i = 32'h5678_9abc;
  logic [15:0] mem_rdata_i   = 16'h0000;
  logic        mem_ack_i     = 1'b0;
  logic        busy_o, done_o, illegal_o, mem_rd_o, mem_wr_o;
  logic [15:0] pc_o, ps_o, sp_o, psw_o, mem_addr_o, mem_wdata_o;
  logic [15:0] e_pc = 16'h0000, e_ps = 16'hffff, e_sp = 16'h0000, e_psw = 16'h8000;
  logic [7:0]  cop [6] = '{8'h75, 8'h76, 8'h71, 8'h79, 8'h7a, 8'h7b};
  logic        tk  [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [7:0]  d;
  int          err_total = 0;
  int          n_checks = 0;

  branch_trap_exec dut (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .start_i       (start_i),
    .byte0_i       (ins[7:0]),
    .byte1_i       (ins[15:8]),
    .byte2_i       (ins[23:16]),
    .byte3_i       (ins[31:24]),
    .byte4_i       (ins[39:32]),
    .reg_operand_i (reg_operand_i),
    .mem_operand_i (mem_operand_i),
    .mem_rdata_i   (mem_rdata_i),
    .mem_ack_i     (mem_ack_i),
    .busy_o        (busy_o),
    .done_o        (done_o),
    .illegal_o     (illegal_o),
    .pc_o          (pc_o),
    .ps_o          (ps_o),
    .sp_o          (sp_o),
    .psw_o         (psw_o),
    .mem_rd_o      (mem_rd_o),
    .mem_wr_o      (mem_wr_o),
    .mem_addr_o    (mem_addr_o),
    .mem_wdata_o   (mem_wdata_o)
  );

  // 20 MHz core clock
  always #25 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function logic [15:0] sx(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // Architectural outputs against the expected copy
  task check_arch;
    chk(pc_o, e_pc);
    chk(ps_o, e_ps);
    chk(sp_o, e_sp);
    chk(psw_o, e_psw);
  endtask

  // One-cycle start with instruction bytes
  task issue(input logic [39:0] v);
    @(posedge mclk_i);
    start_i <= 1'b1;
    ins <= v;
    @(posedge mclk_i);
    start_i <= 1'b0;
  endtask

  // Branch-type instruction, answered one cycle later
  task branch(input logic [39:0] v, input logic [15:0] npc, input logic [15:0] nps);
    issue(v);
    @(negedge mclk_i);
    chk({15'h0000, done_o}, 16'h0001);
    chk({15'h0000, busy_o}, 16'h0000);
    e_pc = npc;
    e_ps = nps;
    check_arch();
  endtask

  // Serve one memory step of a trap
  task step(input logic wr, input logic [15:0] a, input logic [15:0] v);
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge mclk_i);
      if ((wr ? mem_wr_o : mem_rd_o) === 1'b1 && mem_addr_o === a) break;
    end
    chk({15'h0000, (wr ? mem_wr_o : mem_rd_o)}, 16'h0001);
    chk(mem_addr_o, a);
    if (wr) chk(mem_wdata_o, v);
    @(posedge mclk_i);
    mem_ack_i <= 1'b1;
    mem_rdata_i <= v;
    @(posedge mclk_i);
    mem_ack_i <= 1'b0;
  endtask

  // Full trap: two vector reads, three pushes
  task trap(input logic [39:0] v, input logic [15:0] vec, input logic [15:0] npc,
            input logic [15:0] nps, input logic [15:0] len, input logic [15:0] psw_n);
    int k;
    logic [15:0] ret;
    ret = e_pc + len;
    issue(v);
    step(1'b0, vec, npc);
    step(1'b0, vec + 16'h0002, nps);
    step(1'b1, e_sp - 16'h0002, e_psw);
    step(1'b1, e_sp - 16'h0004, e_ps);
    step(1'b1, e_sp - 16'h0006, ret);
    for (k = 0; k < 8 && done_o !== 1'b1; k++) @(negedge mclk_i);
    chk({15'h0000, done_o}, 16'h0001);
    chk({15'h0000, busy_o}, 16'h0001);
    e_pc = npc;
    e_ps = nps;
    e_sp = e_sp - 16'h0006;
    e_psw = psw_n;
    check_arch();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    check_arch();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = (i % 2 == 1) ? 8'h7f : 8'h80;
      branch({24'h0, d, cop[i]}, e_pc + 16'h0002 + (tk[i] ? sx(d) : 16'h0000),
             e_ps);
    end
    $display("test conditional done");
    branch({24'h0, 8'h80, 8'heb}, e_pc + 16'h0002 + sx(8'h80), e_ps);
    branch({16'h0, 16'h8001, 8'he9}, e_pc + 16'h8004, e_ps);
    branch({24'h0, 8'he0, 8'hff}, 16'h1234, e_ps);
    branch({24'h0, 8'h27, 8'hff}, 16'h9abc, e_ps);
    branch({24'h0, 8'h2f, 8'hff}, 16'h9abc, 16'h5678);
    branch({8'hfe, 8'hdc, 8'hba, 8'h98, 8'hea}, 16'hba98, 16'hfedc);
    issue({24'h0, 8'he8, 8'hff});
    @(negedge mclk_i);
    chk({15'h0000, illegal_o}, 16'h0001);
    check_arch();
    $display("test jumps done");
    trap({32'h0, 8'hcc}, 16'h000c, 16'h4000, 16'h2000, 16'h0001, 16'h8000);
    trap({24'h0, 8'hff, 8'hcd}, 16'h03fc, 16'h4100, 16'h2100, 16'h0002, 16'h8000);
    trap({16'h0, 8'h40, 8'hff, 8'h0f}, 16'h0100, 16'h4200, 16'h2200, 16'h0003,
         16'h0000);
    $display("test traps done");
    finish_test();
  end

  // Watchdog far beyond the hundred or so cycles needed
  initial begin
    #200000;
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test();
  end
endmodule
